// [rtl/ipss_pkg.sv]
// Register map, fields and types of the signal select block.
package ipss_pkg;

   // ************
   // Register map (index; byte address is four times the index)
   // ************
   localparam logic [7:0]  IDX_FLAG_SEL   = 8'h84;
   localparam logic [7:0]  IDX_CTRL       = 8'h85;
   localparam logic [7:0]  IDX_ARB        = 8'h86;
   localparam logic [7:0]  IDX_STATUS     = 8'ha0;
   localparam int          ADDR_W         = 10;
   localparam logic [1:0]  ADDR_ALIGN     = 2'h0;
   localparam logic [7:0]  RESET_FLAG_SEL = 8'h00;
   localparam logic [7:0]  RESET_CTRL     = 8'h00;
   localparam logic [7:0]  RESET_ARB      = 8'h00;

   // ************
   // Field positions
   // ************
   localparam int FLAG_A_SEL_LO   = 6;
   localparam int FLAG_B_SEL_LO   = 4;
   localparam int VERT_SEL_LO     = 2;
   localparam int HORIZ_SEL_LO    = 0;
   localparam int BYTE_SWAP_LO    = 6;
   localparam int RANGE_LIMIT_BIT = 5;
   localparam int FLAG_A_INV_BIT  = 4;
   localparam int FLAG_B_INV_BIT  = 3;
   localparam int VERT_INV_BIT    = 2;
   localparam int HORIZ_INV_BIT   = 1;
   localparam int QUAL_INV_BIT    = 0;
   localparam int FLAG_A_MSB_BIT  = 5;
   localparam int FLAG_B_MSB_BIT  = 4;
   localparam int FULL_LVL_LO     = 2;
   localparam int EMPTY_LVL_LO    = 0;

   // ************
   // Codes and limits
   // ************
   localparam logic [2:0] FSEL_FIELD_ID  = 3'h0;
   localparam logic [2:0] FSEL_TASK      = 3'h1;
   localparam logic [2:0] FSEL_SLICED    = 3'h2;
   localparam logic [2:0] FSEL_LOW       = 3'h3;
   localparam logic [2:0] FSEL_FILLED    = 3'h4;
   localparam logic [2:0] FSEL_OVERFLOW  = 3'h5;
   localparam logic [2:0] FSEL_FULL      = 3'h6;
   localparam logic [2:0] FSEL_EMPTY     = 3'h7;
   localparam logic [1:0] REF_GATE       = 2'h0;
   localparam logic [1:0] REF_EXT        = 2'h1;
   localparam logic [1:0] REF_TRIG_GATE  = 2'h2;
   localparam logic [1:0] REF_TRIG_EXT   = 2'h3;
   localparam logic [7:0] CLIP_WIDE_LO   = 8'h01;
   localparam logic [7:0] CLIP_WIDE_HI   = 8'hfe;
   localparam logic [7:0] CLIP_NARROW_LO = 8'h08;
   localparam logic [7:0] CLIP_NARROW_HI = 8'hf7;
   localparam logic [5:0] WORDS_4        = 6'h04;
   localparam logic [5:0] WORDS_8        = 6'h08;
   localparam logic [5:0] WORDS_16       = 6'h10;
   localparam logic [5:0] WORDS_24       = 6'h18;
   localparam logic [5:0] WORDS_28       = 6'h1c;
   localparam logic [5:0] WORDS_32       = 6'h20;
   localparam logic [5:0] WORDS_0        = 6'h00;

   // ************
   // Types
   // ************
   typedef struct packed {
      logic [7:0] arb;
      logic [7:0] ctrl;
      logic [7:0] flag_sel;
   } ipss_cfg_t;

   typedef struct packed {
      logic        field_id;
      logic        task_flag;
      logic        sliced_data;
      logic        almost_filled;
      logic        overflow;
      logic [5:0]  fifo_words;
      logic        h_gate;
      logic        h_in_ref;
      logic        in_window;
      logic        v_gate;
      logic        v_in_ref;
      logic        data_valid;
      logic        code_word;
      logic [31:0] data;
   } ipss_scaler_t;

   typedef struct packed {
      logic        flag_out_a;
      logic        flag_out_b;
      logic        horiz_ref_out;
      logic        vert_ref_out;
      logic        data_qualifier_out;
      logic [31:0] data;
   } ipss_port_t;

endpackage

// [rtl/ipss_signal_select.sv]
// Signal select, polarity, swap and clipping behind an APB slave.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Flag A selector: arb bit5, select bits 7:6
// - Flag A codes 0-3: field, task, sliced, low
// - Flag A codes 4-7: filled, overflow, full, empty
// - Flag B selector: arb bit4, select bits 5:4
// - Flag B uses the same eight-way mapping
// - Horizontal 00 gate, 01 extended gate
// - Horizontal 10/11 trigger on gate edges
// - Vertical 00 gate, 01 input reference
// - Vertical 10/11 trigger from gate or reference
// - Clip video to 1-254 or 8-247
// - Two-bit byte swap within each word
// - Five polarity bits invert five outputs
// - Qualifier and references active high by default
// - Empty and full flags at programmed levels

module ipss_signal_select
   import ipss_pkg::*;
(
   input  wire logic               core_clk_i,
   input  wire logic               sys_rst_i,
   input  wire logic               psel_i,
   input  wire logic               penable_i,
   input  wire logic               pwrite_i,
   input  wire logic [ADDR_W-1:0]  paddr_i,
   input  wire logic [31:0]        pwdata_i,
   input  wire logic [3:0]         pstrb_i,
   output logic                    pready_o,
   output logic                    pslverr_o,
   output logic [31:0]             prdata_o,
   input  wire logic               link_clk_i,
   input  wire ipss_scaler_t       scaler_i,
   output ipss_port_t              port_o
);

   // ************
   // Functions
   // ************
   function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {idx, ADDR_ALIGN};
   endfunction

   function automatic logic [7:0] clip_byte(input logic [7:0] b, input logic narrow);
      logic [7:0] lo;
      logic [7:0] hi;
      lo = narrow ? CLIP_NARROW_LO : CLIP_WIDE_LO;
      hi = narrow ? CLIP_NARROW_HI : CLIP_WIDE_HI;
      if (b < lo)
      begin
         clip_byte = lo;
      end
      else if (b > hi)
      begin
         clip_byte = hi;
      end
      else
      begin
         clip_byte = b;
      end
   endfunction

   function automatic logic flag_mux(input logic [2:0] code, input ipss_scaler_t s,
                                     input logic full, input logic empty);
      case (code)
         FSEL_FIELD_ID: flag_mux = s.field_id;
         FSEL_TASK:     flag_mux = s.task_flag;
         FSEL_SLICED:   flag_mux = s.sliced_data;
         FSEL_LOW:      flag_mux = 1'b0;
         FSEL_FILLED:   flag_mux = s.almost_filled;
         FSEL_OVERFLOW: flag_mux = s.overflow;
         FSEL_FULL:     flag_mux = full;
         FSEL_EMPTY:    flag_mux = empty;
         default:       flag_mux = 1'b0;
      endcase
   endfunction

   // ************
   // APB register slave (core domain)
   // ************
   ipss_cfg_t   cfg;
   logic [4:0]  status_word;
   logic        hit_flag_sel;
   logic        hit_ctrl;
   logic        hit_arb;
   logic        hit_status;
   logic        mapped;
   logic        wr_en;
   logic [31:0] next_rdata;

   assign hit_flag_sel = (paddr_i == reg_addr(IDX_FLAG_SEL));
   assign hit_ctrl     = (paddr_i == reg_addr(IDX_CTRL));
   assign hit_arb      = (paddr_i == reg_addr(IDX_ARB));
   assign hit_status   = (paddr_i == reg_addr(IDX_STATUS));
   assign mapped       = hit_flag_sel | hit_ctrl | hit_arb | hit_status;

   // Zero wait states: the read word is prepared in the setup cycle, so the access cycle ends at once.
   assign pready_o  = psel_i & penable_i;
   assign pslverr_o = psel_i & penable_i & ~mapped;
   assign wr_en     = psel_i & penable_i & pwrite_i & mapped & pstrb_i[0];

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (hit_flag_sel)
      begin
         next_rdata[7:0] = cfg.flag_sel;
      end
      else if (hit_ctrl)
      begin
         next_rdata[7:0] = cfg.ctrl;
      end
      else if (hit_arb)
      begin
         next_rdata[7:0] = cfg.arb;
      end
      else if (hit_status)
      begin
         next_rdata[4:0] = status_word;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         prdata_o <= 32'h0000_0000;
      end
      else if (psel_i && !penable_i && !pwrite_i)
      begin
         prdata_o <= next_rdata;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         cfg.flag_sel <= RESET_FLAG_SEL;
         cfg.ctrl     <= RESET_CTRL;
         cfg.arb      <= RESET_ARB;
      end
      else if (wr_en)
      begin
         if (hit_flag_sel)
         begin
            cfg.flag_sel <= pwdata_i[7:0];
         end
         if (hit_ctrl)
         begin
            cfg.ctrl <= pwdata_i[7:0];
         end
         if (hit_arb)
         begin
            cfg.arb <= pwdata_i[7:0];
         end
      end
   end

   // ************
   // Configuration crossing into the link domain (toggle handshake)
   // ************
   // The sent copy stays frozen while a request is in flight, so the link side always
   // captures a coherent word; a write landing meanwhile goes out on the next round.
   ipss_cfg_t  cfg_sent;
   logic       req_tgl;
   logic       ack_meta;
   logic       ack_sync;
   logic       cfg_pending;

   assign cfg_pending = (req_tgl != ack_sync) | (cfg_sent != cfg);

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         cfg_sent <= '0;
         req_tgl  <= 1'b0;
      end
      else if ((req_tgl == ack_sync) && (cfg_sent != cfg))
      begin
         cfg_sent <= cfg;
         req_tgl  <= ~req_tgl;
      end
   end

   // ********************************************************************
   // Link domain reset and request capture
   // ********************************************************************
   logic       rst_meta;
   logic       link_rst;
   logic       req_meta;
   logic       req_sync;
   logic       req_seen;
   ipss_cfg_t  link_cfg;

   always_ff @(posedge link_clk_i)
   begin
      rst_meta <= sys_rst_i;
      link_rst <= rst_meta;
   end

   always_ff @(posedge link_clk_i)
   begin
      if (link_rst)
      begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end
      else
      begin
         req_meta <= req_tgl;
         req_sync <= req_meta;
      end
   end

   always_ff @(posedge link_clk_i)
   begin
      if (link_rst)
      begin
         req_seen <= 1'b0;
         link_cfg <= '0;
      end
      else if (req_sync != req_seen)
      begin
         req_seen <= req_sync;
         link_cfg <= cfg_sent;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end
      else
      begin
         ack_meta <= req_seen;
         ack_sync <= ack_meta;
      end
   end

   // ********************************************************************
   // FIFO level flags (link domain)
   // ********************************************************************
   logic       almost_empty_flag;
   logic       almost_full_flag;
   logic [1:0] empty_lvl;
   logic [1:0] full_lvl;

   assign empty_lvl = link_cfg.arb[EMPTY_LVL_LO +: 2];
   assign full_lvl  = link_cfg.arb[FULL_LVL_LO +: 2];

   always_comb
   begin
      case (empty_lvl)
         2'h0:    almost_empty_flag = (scaler_i.fifo_words < WORDS_16);
         2'h1:    almost_empty_flag = (scaler_i.fifo_words < WORDS_8);
         2'h2:    almost_empty_flag = (scaler_i.fifo_words < WORDS_4);
         default: almost_empty_flag = (scaler_i.fifo_words == WORDS_0);
      endcase
      case (full_lvl)
         2'h0:    almost_full_flag = (scaler_i.fifo_words >= WORDS_16);
         2'h1:    almost_full_flag = (scaler_i.fifo_words >= WORDS_24);
         2'h2:    almost_full_flag = (scaler_i.fifo_words >= WORDS_28);
         default: almost_full_flag = (scaler_i.fifo_words >= WORDS_32);
      endcase
   end

   // ********************************************************************
   // Output selection (link domain)
   // ********************************************************************
   logic [2:0] flag_a_code;
   logic [2:0] flag_b_code;
   logic [1:0] horiz_sel;
   logic [1:0] vert_sel;
   logic       h_ext_gate;
   logic       h_gate_q;
   logic       h_ext_q;
   logic       v_gate_q;
   logic       v_ref_q;
   logic       sel_a;
   logic       sel_b;
   logic       sel_h;
   logic       sel_v;

   assign flag_a_code = {link_cfg.arb[FLAG_A_MSB_BIT], link_cfg.flag_sel[FLAG_A_SEL_LO +: 2]};
   assign flag_b_code = {link_cfg.arb[FLAG_B_MSB_BIT], link_cfg.flag_sel[FLAG_B_SEL_LO +: 2]};
   assign horiz_sel   = link_cfg.flag_sel[HORIZ_SEL_LO +: 2];
   assign vert_sel    = link_cfg.flag_sel[VERT_SEL_LO +: 2];

   // Inside the scaling window the output gate frames; outside it the input reference passes.
   assign h_ext_gate = scaler_i.in_window ? scaler_i.h_gate : scaler_i.h_in_ref;

   always_ff @(posedge link_clk_i)
   begin
      if (link_rst)
      begin
         h_gate_q <= 1'b0;
         h_ext_q  <= 1'b0;
         v_gate_q <= 1'b0;
         v_ref_q  <= 1'b0;
      end
      else
      begin
         h_gate_q <= scaler_i.h_gate;
         h_ext_q  <= h_ext_gate;
         v_gate_q <= scaler_i.v_gate;
         v_ref_q  <= scaler_i.v_in_ref;
      end
   end

   assign sel_a = flag_mux(flag_a_code, scaler_i, almost_full_flag, almost_empty_flag);
   assign sel_b = flag_mux(flag_b_code, scaler_i, almost_full_flag, almost_empty_flag);

   always_comb
   begin
      case (horiz_sel)
         REF_GATE:      sel_h = scaler_i.h_gate;
         REF_EXT:       sel_h = h_ext_gate;
         REF_TRIG_GATE: sel_h = scaler_i.h_gate & ~h_gate_q;
         REF_TRIG_EXT:  sel_h = h_ext_gate & ~h_ext_q;
         default:       sel_h = 1'b0;
      endcase
      case (vert_sel)
         REF_GATE:      sel_v = scaler_i.v_gate;
         REF_EXT:       sel_v = scaler_i.v_in_ref;
         REF_TRIG_GATE: sel_v = scaler_i.v_gate & ~v_gate_q;
         REF_TRIG_EXT:  sel_v = scaler_i.v_in_ref & ~v_ref_q;
         default:       sel_v = 1'b0;
      endcase
   end

   // ********************************************************************
   // Data path: clip, swap (link domain)
   // ********************************************************************
   // Timing codes carry 00 and ff on purpose, so clipping is skipped for them.
   logic        narrow;
   logic [31:0] clipped;
   logic [31:0] swapped;
   logic [1:0]  swap_sel;

   assign narrow   = link_cfg.ctrl[RANGE_LIMIT_BIT];
   assign swap_sel = link_cfg.ctrl[BYTE_SWAP_LO +: 2];

   always_comb
   begin
      clipped = scaler_i.data;
      if (!scaler_i.code_word)
      begin
         for (int i = 0; i < 4; i++)
         begin
            clipped[i*8 +: 8] = clip_byte(scaler_i.data[i*8 +: 8], narrow);
         end
      end
   end

   // Byte lane 0 carries the first byte of the word (D0).
   always_comb
   begin
      case (swap_sel)
         2'h1:    swapped = {clipped[23:16], clipped[31:24], clipped[7:0], clipped[15:8]};
         2'h2:    swapped = {clipped[15:0], clipped[31:16]};
         2'h3:    swapped = {clipped[7:0], clipped[15:8], clipped[23:16], clipped[31:24]};
         default: swapped = clipped;
      endcase
   end

   // ********************************************************************
   // Polarity and output registers (link domain)
   // ********************************************************************
   always_ff @(posedge link_clk_i)
   begin
      if (link_rst)
      begin
         port_o <= '0;
      end
      else
      begin
         port_o.flag_out_a         <= sel_a ^ link_cfg.ctrl[FLAG_A_INV_BIT];
         port_o.flag_out_b         <= sel_b ^ link_cfg.ctrl[FLAG_B_INV_BIT];
         port_o.horiz_ref_out      <= sel_h ^ link_cfg.ctrl[HORIZ_INV_BIT];
         port_o.vert_ref_out       <= sel_v ^ link_cfg.ctrl[VERT_INV_BIT];
         port_o.data_qualifier_out <= scaler_i.data_valid ^ link_cfg.ctrl[QUAL_INV_BIT];
         port_o.data               <= swapped;
      end
   end

   // ********************************************************************
   // Status back to the core domain
   // ********************************************************************
   // Each status bit is an independent level, so per-bit synchronisers suffice.
   logic [3:0] link_status;
   logic [3:0] stat_meta;
   logic [3:0] stat_sync;

   always_ff @(posedge link_clk_i)
   begin
      if (link_rst)
      begin
         link_status <= 4'h0;
      end
      else
      begin
         link_status <= {scaler_i.almost_filled, scaler_i.overflow, almost_full_flag, almost_empty_flag};
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         stat_meta <= 4'h0;
         stat_sync <= 4'h0;
      end
      else
      begin
         stat_meta <= link_status;
         stat_sync <= stat_meta;
      end
   end

   assign status_word = {cfg_pending, stat_sync};

endmodule

`default_nettype wire

// [tb/ipss_capture_model.sv]
// Capture model of the image port.
`timescale 1ns/100ps
`default_nettype none
module ipss_capture_model
   import ipss_pkg::*;
(
   input  wire logic       link_clk_i,
   input  wire ipss_port_t port_i,
   output ipss_port_t      seen_o
);
   // No reset: it only mirrors the port.
   always_ff @(posedge link_clk_i)
   begin
      seen_o <= port_i;
   end
endmodule
`default_nettype wire

// [tb/ipss_signal_select_props.sv]
// Checker of the signal select block.
`timescale 1ns/100ps
`default_nettype none
module ipss_signal_select_props
   import ipss_pkg::*;
(
   input wire logic              core_clk_i,
   input wire logic              sys_rst_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic [3:0]        pstrb_i,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   input wire logic [31:0]       prdata_o,
   input wire logic              link_clk_i,
   input wire ipss_scaler_t      scaler_i,
   input wire ipss_port_t        port_o
);
   localparam logic [ADDR_W-1:0] A_FSEL = {IDX_FLAG_SEL, ADDR_ALIGN};
   localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, ADDR_ALIGN};
   localparam logic [ADDR_W-1:0] A_ARB  = {IDX_ARB, ADDR_ALIGN};
   localparam logic [ADDR_W-1:0] A_STAT = {IDX_STATUS, ADDR_ALIGN};
   logic [7:0] fsel;
   logic [7:0] ctl;
   logic [7:0] arb;
   logic [5:0] quiet;

   function automatic logic [7:0] srcvec(input ipss_scaler_t x, input logic [3:0] lv);
      logic e;
      logic f;
      e = lv[1] ? (lv[0] ? x.fifo_words == WORDS_0 : x.fifo_words < WORDS_4)
                : (lv[0] ? x.fifo_words < WORDS_8 : x.fifo_words < WORDS_16);
      f = lv[3] ? (lv[2] ? x.fifo_words >= WORDS_32 : x.fifo_words >= WORDS_28)
                : (lv[2] ? x.fifo_words >= WORDS_24 : x.fifo_words >= WORDS_16);
      return {e, f, x.overflow, x.almost_filled, 1'b0, x.sliced_data, x.task_flag, x.field_id};
   endfunction

   function automatic logic in_lim(input logic [31:0] d, input logic nar);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         ok &= nar ? d[8*i+:8] inside {[CLIP_NARROW_LO:CLIP_NARROW_HI]} : d[8*i+:8] inside {[CLIP_WIDE_LO:CLIP_WIDE_HI]};
      end
      return ok;
   endfunction

   wire logic       acc     = psel_i & penable_i;
   wire logic       mapped  = paddr_i inside {A_FSEL, A_CTRL, A_ARB, A_STAT};
   // Link checks wait until a new setting has landed.
   wire logic       settled = (quiet == 6'h3f);
   wire logic [7:0] srcs    = srcvec(scaler_i, arb[3:0]);
   wire logic       hsrc    = fsel[0] ? (scaler_i.in_window ? scaler_i.h_gate : scaler_i.h_in_ref) : scaler_i.h_gate;
   wire logic       vsrc    = fsel[2] ? scaler_i.v_in_ref : scaler_i.v_gate;

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         fsel  <= RESET_FLAG_SEL;
         ctl   <= RESET_CTRL;
         arb   <= RESET_ARB;
         quiet <= 6'h00;
      end
      else if (acc && pwrite_i && pstrb_i[0])
      begin
         if (paddr_i == A_FSEL) fsel <= pwdata_i[7:0];
         if (paddr_i == A_CTRL) ctl <= pwdata_i[7:0];
         if (paddr_i == A_ARB) arb <= pwdata_i[7:0];
         quiet <= 6'h00;
      end
      else if (!settled)
      begin
         quiet <= quiet + 6'h01;
      end
   end

   sequence h_pulse_s;
      port_o.horiz_ref_out != ctl[1] ##1 port_o.horiz_ref_out == ctl[1];
   endsequence

   apb_answer_a:
   assert property (@(posedge core_clk_i) disable iff (sys_rst_i) acc |-> pready_o && pslverr_o == !mapped)
      else $error("bad answer");
   sel_readback_a:
   assert property (@(posedge core_clk_i) disable iff (sys_rst_i) acc && !pwrite_i && paddr_i == A_FSEL |-> prdata_o == {24'h0, fsel})
      else $error("bad readback");
   flag_a_sel_a:
   assert property (@(posedge link_clk_i) disable iff (sys_rst_i) settled |-> port_o.flag_out_a == ($past(srcs[{arb[5], fsel[7:6]}]) ^ ctl[4]))
      else $error("flag a wrong");
   flag_b_sel_a:
   assert property (@(posedge link_clk_i) disable iff (sys_rst_i) settled |-> port_o.flag_out_b == ($past(srcs[{arb[4], fsel[5:4]}]) ^ ctl[3]))
      else $error("flag b wrong");
   horiz_gate_a:
   assert property (@(posedge link_clk_i) disable iff (sys_rst_i) settled && !fsel[1] |-> port_o.horiz_ref_out == ($past(hsrc) ^ ctl[1]))
      else $error("h gate wrong");
   horiz_trig_a:
   assert property (@(posedge link_clk_i) disable iff (sys_rst_i) settled && fsel[1] && $rose(hsrc) |=> h_pulse_s)
      else $error("h pulse wrong");
   vert_ref_a:
   assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      settled |-> port_o.vert_ref_out == ((fsel[3] ? $past(vsrc) & !$past(vsrc, 2) : $past(vsrc)) ^ ctl[2]))
      else $error("v ref wrong");
   qual_pol_a:
   assert property (@(posedge link_clk_i) disable iff (sys_rst_i) settled |-> port_o.data_qualifier_out == ($past(scaler_i.data_valid) ^ ctl[0]))
      else $error("qualifier wrong");
   clip_range_a:
   assert property (@(posedge link_clk_i) disable iff (sys_rst_i) settled && !$past(scaler_i.code_word) |-> in_lim(port_o.data, ctl[5]))
      else $error("byte not clipped");
endmodule

bind ipss_signal_select ipss_signal_select_props ipss_signal_select_props_inst (
   .core_clk_i (core_clk_i),
   .sys_rst_i  (sys_rst_i),
   .psel_i     (psel_i),
   .penable_i  (penable_i),
   .pwrite_i   (pwrite_i),
   .paddr_i    (paddr_i),
   .pwdata_i   (pwdata_i),
   .pstrb_i    (pstrb_i),
   .pready_o   (pready_o),
   .pslverr_o  (pslverr_o),
   .prdata_o   (prdata_o),
   .link_clk_i (link_clk_i),
   .scaler_i   (scaler_i),
   .port_o     (port_o)
);
`default_nettype wire

// [tb/tb_top.sv]
// Bench of the signal select block.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
      end \
   end
module tb_top
   import ipss_pkg::*;
;
   localparam logic [ADDR_W-1:0] A_FSEL = {IDX_FLAG_SEL, ADDR_ALIGN};
   localparam logic [ADDR_W-1:0] A_CTRL = {IDX_CTRL, ADDR_ALIGN};
   localparam logic [ADDR_W-1:0] A_ARB  = {IDX_ARB, ADDR_ALIGN};
   localparam logic [7:0]        FLAGS  = 8'h55;
   logic              core_clk;
   logic              link_clk;
   logic              rst = 1'b1;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0;
   logic [3:0]        pstrb = '0;
   logic              pready;
   logic              pslverr;
   logic [31:0]       prdata;
   ipss_scaler_t      scaler = '0;
   ipss_scaler_t      v;
   ipss_port_t        iport;
   ipss_port_t        seen;
   logic [31:0]       q;
   logic              err;
   logic [2:0]        hs;
   logic [2:0]        vs;
   int                fail_count = 0;
   int                n_compared = 0;
   logic [5:0]        full_thr [4] = '{WORDS_16, WORDS_24, WORDS_28, WORDS_32};
   logic [5:0]        empty_thr [4] = '{WORDS_16, WORDS_8, WORDS_4, 6'h01};
   logic [31:0]       swap_tab [4] = '{32'h44332211, 32'h33441122, 32'h22114433, 32'h11223344};
   logic [31:0]       clip_tab [3] = '{32'h0107f8fe, 32'h0808f7f7, 32'h0007f8ff};

   ipss_signal_select ipss_signal_select_inst (
      .core_clk_i (core_clk),
      .sys_rst_i  (rst),
      .psel_i     (psel),
      .penable_i  (penable),
      .pwrite_i   (pwrite),
      .paddr_i    (paddr),
      .pwdata_i   (pwdata),
      .pstrb_i    (pstrb),
      .pready_o   (pready),
      .pslverr_o  (pslverr),
      .prdata_o   (prdata),
      .link_clk_i (link_clk),
      .scaler_i   (scaler),
      .port_o     (iport)
   );

   ipss_capture_model ipss_capture_model_inst (
      .link_clk_i (link_clk),
      .port_i     (iport),
      .seen_o     (seen)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   initial
   begin
      link_clk = 1'b0;
      #3.7;
      forever #15 link_clk = ~link_clk;
   end

   // ************
   // Access tasks
   // ************
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      pstrb   <= 4'hf;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic cfg(input logic [7:0] f, input logic [7:0] c, input logic [7:0] a);
      apb(1'b1, A_FSEL, f);
      apb(1'b1, A_CTRL, c);
      apb(1'b1, A_ARB, a);
      repeat (12) @(posedge link_clk);
   endtask

   // The capture model adds one link edge of delay.
   task automatic drive(input ipss_scaler_t x);
      @(posedge link_clk);
      scaler <= x;
      repeat (4) @(posedge link_clk);
      @(negedge link_clk);
   endtask

   task automatic report_and_stop;
      if (fail_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #300us;
      fail_count++;
      report_and_stop();
   end

   // ************
   // Test sequence
   // ************
   initial
   begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      apb(1'b0, A_FSEL, 8'h00);
      `CHK("fsel reset", {24'h0, RESET_FLAG_SEL}, q)
      apb(1'b0, A_CTRL, 8'h00);
      `CHK("ctrl reset", {24'h0, RESET_CTRL}, q)
      apb(1'b1, A_CTRL, 8'h5a);
      apb(1'b0, A_CTRL, 8'h00);
      `CHK("ctrl readback", 32'h0000005a, q)
      apb(1'b0, 10'h3fc, 8'h00);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0, q)
      v = '0;
      v.field_id = 1'b1;
      v.sliced_data = 1'b1;
      v.almost_filled = 1'b1;
      v.fifo_words = 6'h14;
      for (int s = 0; s < 8; s++)
      begin
         cfg({s[1:0], ~s[1:0], 4'h0}, 8'h08, {2'h0, s[2], ~s[2], 4'h0});
         drive(v);
         `CHK("flag a", FLAGS[s], seen.flag_out_a)
         `CHK("flag b", ~FLAGS[7-s], seen.flag_out_b)
      end
      for (int lv = 0; lv < 4; lv++)
      begin
         cfg(8'hb0, 8'h00, {4'h3, lv[1:0], lv[1:0]});
         for (int k = 0; k < 2; k++)
         begin
            v.fifo_words = full_thr[lv] - 6'(k);
            drive(v);
            `CHK("almost full", k == 0, seen.flag_out_a)
            v.fifo_words = empty_thr[lv] - 6'(1 - k);
            drive(v);
            `CHK("almost empty", k == 0, seen.flag_out_b)
         end
      end
      v = '0;
      v.h_in_ref = 1'b1;
      v.v_in_ref = 1'b1;
      v.data_valid = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         cfg(m[0] ? 8'h05 : 8'h00, {5'h00, {3{m[1]}}}, 8'h00);
         drive(v);
         `CHK("h ref", m[0] ^ m[1], seen.horiz_ref_out)
         `CHK("v ref", m[0] ^ m[1], seen.vert_ref_out)
         `CHK("qualifier", ~m[1], seen.data_qualifier_out)
      end
      for (int t = 0; t < 2; t++)
      begin
         v = '0;
         cfg(t ? 8'h0f : 8'h0a, 8'h00, 8'h00);
         drive(v);
         @(posedge link_clk);
         scaler.h_in_ref <= 1'b1;
         scaler.v_in_ref <= 1'b1;
         for (int i = 0; i < 3; i++)
         begin
            @(negedge link_clk);
            hs[i] = iport.horiz_ref_out;
            vs[i] = iport.vert_ref_out;
         end
         `CHK("h trig", t ? 3'b010 : 3'b000, hs)
         `CHK("v trig", t ? 3'b010 : 3'b000, vs)
      end
      v = '0;
      v.data = 32'h44332211;
      for (int s = 0; s < 4; s++)
      begin
         cfg(8'h00, {s[1:0], 6'h00}, 8'h00);
         drive(v);
         `CHK("byte swap", swap_tab[s], seen.data)
      end
      v.data = 32'h0007f8ff;
      for (int c = 0; c < 3; c++)
      begin
         v.code_word = (c == 2);
         cfg(8'h00, {2'h0, c != 0, 5'h00}, 8'h00);
         drive(v);
         `CHK("range clip", clip_tab[c], seen.data)
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
